// File: verilog/dbs_defines.vh
`ifndef DBS_DEFINES_VH
`define DBS_DEFINES_VH

// ----------------------------------------------------------------------
// Command codes as {cs_n, ras_n, cas_n, we_n} at a rising clock edge.
// ----------------------------------------------------------------------
`define DBS_CMD_ACT         4'h3
`define DBS_CMD_READ        4'h5
`define DBS_CMD_WRITE       4'h4
`define DBS_CMD_PRE         4'h2
`define DBS_CMD_BST         4'h6

// ----------------------------------------------------------------------
// Address fields and burst length codes.
// ----------------------------------------------------------------------
`define DBS_ADDR_AUTO_CLOSE 8
`define DBS_COL_W           8
`define DBS_BL_CODE_2       2'h1
`define DBS_BL_CODE_4       2'h2
`define DBS_BL_CODE_8       2'h3

// ----------------------------------------------------------------------
// Timing counter width, in link clock cycles.
// ----------------------------------------------------------------------
`define DBS_CNT_W           8

`endif

// File: verilog/dbs_fifo.v
`timescale 1ns/1ps
`default_nettype none

module dbs_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  // Clock and reset
  input  wire             i_clk,
  input  wire             i_rst_n,
  // Fill side
  input  wire             i_in_valid,
  output wire             o_in_ready,
  input  wire [WIDTH-1:0] i_in_data,
  // Drain side
  output wire             o_out_valid,
  input  wire             i_out_ready,
  output wire [WIDTH-1:0] o_out_data
);

  reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_reg;
  reg [AW-1:0]    rd_ptr_reg;
  reg [AW:0]      count_reg;
  wire            push;
  wire            pop;

  // --------------------------------------------------------------------
  // Flags come from the occupancy count, so full and empty stay honest.
  // --------------------------------------------------------------------
  assign o_in_ready  = (count_reg != DEPTH[AW:0]);
  assign o_out_valid = (count_reg != {(AW+1){1'b0}});
  assign o_out_data  = mem_reg[rd_ptr_reg];
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;

  // Storage has no reset; only the pointers and the count carry control state.
  always @(posedge i_clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= i_in_data;
    end
  end

  // Pointers wrap at the depth, which need not be a power of two.
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == DEPTH[AW-1:0] - 1'b1) ?
                      {AW{1'b0}} : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == DEPTH[AW-1:0] - 1'b1) ?
                      {AW{1'b0}} : rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// File: verilog/dbs_core.v
`timescale 1ns/1ps
`default_nettype none
`include "dbs_defines.vh"

module dbs_core #(
  parameter DW = 32,
  parameter MW = 4
) (
  // System clock and reset
  input  wire                  i_sys_clk,
  input  wire                  i_nrst,
  // Link pins, all asynchronous to the system clock
  input  wire                  i_ck,
  input  wire                  i_cs_n,
  input  wire                  i_ras_n,
  input  wire                  i_cas_n,
  input  wire                  i_we_n,
  input  wire [1:0]            i_ba,
  input  wire [11:0]           i_addr,
  input  wire [DW-1:0]         i_dq_in,
  input  wire                  i_dqs_in,
  input  wire [MW-1:0]         i_write_byte_mask,
  output reg  [DW-1:0]         o_dq_out,
  output reg                   o_dq_oe,
  output reg                   o_dqs_out,
  output reg                   o_dqs_oe,
  // Configuration; latency and times in link clock cycles, burst length as a code
  input  wire [2:0]            i_column_latency,
  input  wire [1:0]            i_burst_length_setting,
  input  wire [`DBS_CNT_W-1:0] i_write_recovery_time,
  input  wire [`DBS_CNT_W-1:0] i_row_precharge_time,
  input  wire [`DBS_CNT_W-1:0] i_row_active_min_time,
  // Write beats towards the array
  output wire                  o_wr_valid,
  input  wire                  i_wr_ready,
  output wire [1:0]            o_wr_bank,
  output wire [`DBS_COL_W-1:0] o_wr_col,
  output wire [DW-1:0]         o_wr_data,
  output wire [MW-1:0]         o_wr_mask,
  // Read data from the array
  output reg  [1:0]            o_rd_bank,
  output reg  [`DBS_COL_W-1:0] o_rd_col,
  input  wire [DW-1:0]         i_rd_data,
  // Status
  output reg  [3:0]            o_bank_open,
  output reg  [3:0]            o_bank_closing,
  output reg                   o_wr_overflow,
  input  wire                  i_clr_overflow
);

  localparam SW = 4 + 2 + 12 + DW + MW + 2;
  localparam FW = 2 + `DBS_COL_W + DW + MW;
  localparam CW = `DBS_CNT_W;

  // Beats in a burst from its length code.
  function [3:0] bl_beats;
    input [1:0] code;
    begin
      case (code)
        `DBS_BL_CODE_4: bl_beats = 4'h4;
        `DBS_BL_CODE_8: bl_beats = 4'h8;
        default:        bl_beats = 4'h2;
      endcase
    end
  endfunction

  // Saturating decrement, used by the write recovery, close delay and precharge counters.
  function [CW-1:0] dec;
    input [CW-1:0] v;
    begin
      dec = (v == {CW{1'b0}}) ? v : v - 1'b1;
    end
  endfunction

  // ----------------------------------------------------------------------
  // Reset release and pin synchronisers.
  // ----------------------------------------------------------------------
  reg           rst_a_reg;
  reg           rst_n;
  reg [SW-1:0]  s1_reg;
  reg [SW-1:0]  s2_reg;
  reg           ck_d_reg;
  reg           dqs_d_reg;

  // Release is delayed two clocks so every flop leaves reset together.
  always @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rst_a_reg <= 1'b0;
      rst_n     <= 1'b0;
    end else begin
      rst_a_reg <= 1'b1;
      rst_n     <= rst_a_reg;
    end
  end

  // First stage feeds only the second; edges are found after it.
  always @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg    <= {SW{1'b0}};
      s2_reg    <= {SW{1'b0}};
      ck_d_reg  <= 1'b0;
      dqs_d_reg <= 1'b0;
    end else begin
      s1_reg    <= {i_cs_n, i_ras_n, i_cas_n, i_we_n, i_ba, i_addr,
                    i_dq_in, i_write_byte_mask, i_ck, i_dqs_in};
      s2_reg    <= s1_reg;
      ck_d_reg  <= s2_reg[1];
      dqs_d_reg <= s2_reg[0];
    end
  end

  wire [3:0]    cmd    = s2_reg[SW-1:SW-4];
  wire [1:0]    ba     = s2_reg[SW-5:SW-6];
  wire [11:0]   addr   = s2_reg[SW-7:SW-18];
  wire [DW-1:0] dq     = s2_reg[MW+DW+1:MW+2];
  wire [MW-1:0] dm     = s2_reg[MW+1:2];
  wire          ck_r   = s2_reg[1] && !ck_d_reg;
  wire          ck_f   = !s2_reg[1] && ck_d_reg;
  wire          dqs_e  = s2_reg[0] ^ dqs_d_reg;

  wire is_act  = ck_r && (cmd == `DBS_CMD_ACT);
  wire is_rd   = ck_r && (cmd == `DBS_CMD_READ);
  wire is_wr   = ck_r && (cmd == `DBS_CMD_WRITE);
  wire is_pre  = ck_r && (cmd == `DBS_CMD_PRE);
  wire is_bst  = ck_r && (cmd == `DBS_CMD_BST);
  wire [3:0] bl = bl_beats(i_burst_length_setting);

  // ----------------------------------------------------------------------
  // Write burst engine and recovery timer.
  // ----------------------------------------------------------------------
  reg [3:0]            wr_left_reg;
  reg [1:0]            wr_bank_reg;
  reg [`DBS_COL_W-1:0] wr_col_reg;
  reg                  wr_ap_reg;
  reg                  twr_arm_reg;
  reg                  twr_run_reg;
  reg [CW-1:0]         twr_cnt_reg;
  reg [1:0]            twr_bank_reg;
  wire                 beat = dqs_e && (wr_left_reg != 4'h0);
  // A beat with every lane masked is dropped here and never queued.
  wire                 keep = beat && (dm != {MW{1'b1}});
  wire                 f_ready;
  wire                 wr_fire = ck_r && twr_run_reg && (twr_cnt_reg <= 1);

  // A beat arriving while the queue is full is lost and flagged,
  // because the link cannot be paused in the middle of a burst.
  always @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_left_reg   <= 4'h0;
      wr_bank_reg   <= 2'h0;
      wr_col_reg    <= {`DBS_COL_W{1'b0}};
      wr_ap_reg     <= 1'b0;
      twr_arm_reg   <= 1'b0;
      twr_run_reg   <= 1'b0;
      twr_cnt_reg   <= {CW{1'b0}};
      twr_bank_reg  <= 2'h0;
      o_wr_overflow <= 1'b0;
    end else begin
      if (keep && !f_ready) begin
        o_wr_overflow <= 1'b1;
      end else if (i_clr_overflow) begin
        o_wr_overflow <= 1'b0;
      end
      if (is_wr) begin
        wr_left_reg <= bl;
        wr_bank_reg <= ba;
        wr_col_reg  <= addr[`DBS_COL_W-1:0];
        wr_ap_reg   <= addr[`DBS_ADDR_AUTO_CLOSE];
        twr_arm_reg <= 1'b0;
      end else if (beat) begin
        wr_left_reg <= wr_left_reg - 4'h1;
        wr_col_reg  <= wr_col_reg + 1'b1;
        if (wr_left_reg == 4'h1) begin
          twr_arm_reg <= wr_ap_reg;
        end
      end
      // Recovery opens on the first clock rise after the last beat.
      if (ck_r && twr_arm_reg && !is_wr) begin
        twr_arm_reg  <= 1'b0;
        twr_run_reg  <= 1'b1;
        twr_cnt_reg  <= i_write_recovery_time;
        twr_bank_reg <= wr_bank_reg;
      end else if (wr_fire) begin
        twr_run_reg <= 1'b0;
      end else if (ck_r) begin
        twr_cnt_reg <= dec(twr_cnt_reg);
      end
    end
  end

  // ----------------------------------------------------------------------
  // Per-bank row state, row active time and precharge scheduling.
  // ----------------------------------------------------------------------
  reg [CW-1:0] ras_cnt_reg [0:3];
  reg [CW-1:0] ap_cnt_reg  [0:3];
  reg [CW-1:0] rp_cnt_reg  [0:3];
  reg [3:0]    pend_reg;
  integer      b;

  // A pending close waits both its own delay and the row active time.
  always @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_reg       <= 4'h0;
      o_bank_open    <= 4'h0;
      o_bank_closing <= 4'h0;
      for (b = 0; b < 4; b = b + 1) begin
        ras_cnt_reg[b] <= {CW{1'b0}};
        ap_cnt_reg[b]  <= {CW{1'b0}};
        rp_cnt_reg[b]  <= {CW{1'b0}};
      end
    end else if (ck_r) begin
      for (b = 0; b < 4; b = b + 1) begin
        if (ras_cnt_reg[b] != {CW{1'b1}}) begin
          ras_cnt_reg[b] <= ras_cnt_reg[b] + 1'b1;
        end
        ap_cnt_reg[b] <= dec(ap_cnt_reg[b]);
        rp_cnt_reg[b] <= dec(rp_cnt_reg[b]);
        if (rp_cnt_reg[b] <= 1) begin
          o_bank_closing[b] <= 1'b0;
        end
        if (is_act && ba == b) begin
          o_bank_open[b] <= 1'b1;
          ras_cnt_reg[b] <= {CW{1'b0}};
        end else if (o_bank_open[b] &&
                     ((pend_reg[b] && ap_cnt_reg[b] <= 1) ||
                      (wr_fire && twr_bank_reg == b) ||
                      (is_pre && ba == b)) &&
                     ({1'b0, ras_cnt_reg[b]} + 9'h001 >=
                      {1'b0, i_row_active_min_time})) begin
          o_bank_open[b]    <= 1'b0;
          o_bank_closing[b] <= 1'b1;
          pend_reg[b]       <= 1'b0;
          rp_cnt_reg[b]     <= i_row_precharge_time;
        end else if (o_bank_open[b] && ((is_pre && ba == b) ||
                     (wr_fire && twr_bank_reg == b))) begin
          pend_reg[b]   <= 1'b1;
          ap_cnt_reg[b] <= {CW{1'b0}};
        end else if (is_rd && ba == b && addr[`DBS_ADDR_AUTO_CLOSE]) begin
          pend_reg[b]   <= 1'b1;
          ap_cnt_reg[b] <= {{(CW-3){1'b0}}, bl[3:1]};
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Read burst engine with burst stop.
  // ----------------------------------------------------------------------
  reg [3:0] rd_left_reg;
  reg [2:0] rd_wait_reg;
  reg [2:0] stop_wait_reg;
  reg       rd_ap_reg;

  // Beats leave on both clock edges once the column latency has passed.
  always @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_left_reg   <= 4'h0;
      rd_wait_reg   <= 3'h0;
      stop_wait_reg <= 3'h0;
      rd_ap_reg     <= 1'b0;
      o_rd_bank     <= 2'h0;
      o_rd_col      <= {`DBS_COL_W{1'b0}};
      o_dq_out      <= {DW{1'b0}};
      o_dq_oe       <= 1'b0;
      o_dqs_out     <= 1'b0;
      o_dqs_oe      <= 1'b0;
    end else begin
      if (is_rd) begin
        rd_left_reg   <= bl;
        rd_wait_reg   <= i_column_latency;
        stop_wait_reg <= 3'h0;
        rd_ap_reg     <= addr[`DBS_ADDR_AUTO_CLOSE];
        o_rd_bank     <= ba;
        o_rd_col      <= addr[`DBS_COL_W-1:0];
      end else begin
        // The stop timer runs beside the beats, so a stop never eats one.
        if (is_bst && !rd_ap_reg && rd_left_reg != 4'h0) begin
          stop_wait_reg <= i_column_latency;
        end else if (ck_r && stop_wait_reg != 3'h0) begin
          stop_wait_reg <= stop_wait_reg - 3'h1;
        end
        // With a column latency of one or more, the first beat waits for a clock rise, never a fall.
        if (ck_r && stop_wait_reg == 3'h1) begin
          rd_left_reg <= 4'h0;
          o_dq_oe     <= 1'b0;
          o_dqs_oe    <= 1'b0;
          o_dqs_out   <= 1'b0;
        end else if (((ck_r && rd_wait_reg <= 3'h1) ||
                      (ck_f && rd_wait_reg == 3'h0)) &&
                     rd_left_reg != 4'h0) begin
          if (ck_r) begin
            rd_wait_reg <= 3'h0;
          end
          rd_left_reg <= rd_left_reg - 4'h1;
          o_rd_col    <= o_rd_col + 1'b1;
          o_dq_out    <= i_rd_data;
          o_dq_oe     <= 1'b1;
          o_dqs_out   <= ck_r;
          o_dqs_oe    <= 1'b1;
        end else if (ck_r || ck_f) begin
          if (ck_r) begin
            rd_wait_reg <= (rd_wait_reg == 3'h0) ? 3'h0 : rd_wait_reg - 3'h1;
          end
          o_dq_oe   <= 1'b0;
          o_dqs_oe  <= 1'b0;
          o_dqs_out <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Queue of stored write beats towards the array.
  // ----------------------------------------------------------------------
  dbs_fifo #(
    .WIDTH (FW),
    .DEPTH (8),
    .AW    (3)
  ) u_fifo (
    .i_clk       (i_sys_clk),
    .i_rst_n     (rst_n),
    .i_in_valid  (keep),
    .o_in_ready  (f_ready),
    .i_in_data   ({wr_bank_reg, wr_col_reg, dq, dm}),
    .o_out_valid (o_wr_valid),
    .i_out_ready (i_wr_ready),
    .o_out_data  ({o_wr_bank, o_wr_col, o_wr_data, o_wr_mask})
  );

endmodule

`default_nettype wire

// File: verilog/dbs_core_unused_guard.v
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// File: dv/dbs_core_chk.sv
`timescale 1ns/1ps
`default_nettype none
module dbs_core_chk (
  // Clock, reset and watched inputs
  input wire logic        i_sys_clk,
  input wire logic        i_nrst,
  input wire logic        i_ck,
  input wire logic        i_wr_ready,
  input wire logic [7:0]  i_row_active_min_time,
  // Watched outputs
  input wire logic [31:0] o_dq_out,
  input wire logic        o_dq_oe,
  input wire logic        o_dqs_out,
  input wire logic        o_dqs_oe,
  input wire logic        o_wr_valid,
  input wire logic [31:0] o_wr_data,
  input wire logic [3:0]  o_wr_mask,
  input wire logic [7:0]  o_wr_col,
  input wire logic [3:0]  o_bank_open,
  input wire logic [3:0]  o_bank_closing
);
  logic        ck_reg;
  logic [7:0]  ck_age_reg;
  logic [15:0] open_age_reg;

  // Ages of the link clock level and of the row open in bank two.
  always @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ck_reg       <= 1'b0;
      ck_age_reg   <= 8'h00;
      open_age_reg <= 16'h0000;
    end else begin
      ck_reg       <= i_ck;
      ck_age_reg   <= (ck_reg != i_ck) ? 8'h00 :
                      (ck_age_reg == 8'hFF) ? 8'hFF : ck_age_reg + 8'h01;
      open_age_reg <= !o_bank_open[2] ? 16'h0000 :
                      (open_age_reg == 16'hFFFF) ? 16'hFFFF :
                      open_age_reg + 16'h0001;
    end
  end

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);

  a_strobe_data_pair: assert property (o_dq_oe == o_dqs_oe)
    else $error("data and strobe enables differ");
  a_full_mask_drop: assert property (o_wr_valid |-> o_wr_mask != 4'hF)
    else $error("fully masked beat queued");
  a_beat_held: assert property (o_wr_valid && !i_wr_ready |=>
    o_wr_valid && $stable({o_wr_data, o_wr_mask, o_wr_col}))
    else $error("queued beat changed while stalled");
  a_oe_on_rise: assert property ($changed(o_dq_oe) |->
    i_ck && ck_age_reg <= 8'h06)
    else $error("output enable moved away from a clock rise");
  a_beat_flips_strobe: assert property (o_dqs_oe && $past(o_dqs_oe) &&
    $changed(o_dq_out) |-> $changed(o_dqs_out))
    else $error("read beat without strobe edge");
  a_close_from_open: assert property ((o_bank_closing &
    ~$past(o_bank_closing) & (o_bank_open | ~$past(o_bank_open))) == 4'h0)
    else $error("precharge started on a bank that was not open");
  a_row_time_met: assert property ($rose(o_bank_closing[2]) |->
    open_age_reg + 16'h0002 >= i_row_active_min_time * 16'h000F)
    else $error("precharge before minimum row time");
  a_closing_lasts: assert property ($rose(o_bank_closing[0]) |->
    o_bank_closing[0] [*8])
    else $error("precharge period cut short");
endmodule
`default_nettype wire

// File: dv/dbs_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
module dbs_ctrl_model (
  // Link clock
  input wire logic    i_ck,
  // Command and address pins
  output logic        o_cs_n,
  output logic        o_ras_n,
  output logic        o_cas_n,
  output logic        o_we_n,
  output logic [1:0]  o_ba,
  output logic [11:0] o_addr,
  // Write data, strobe and byte mask
  output logic [31:0] o_dq,
  output logic        o_dqs,
  output logic [3:0]  o_dm
);
  // Start deselected with the strobe parked low.
  initial begin
    {o_cs_n, o_ras_n, o_cas_n, o_we_n} = 4'hF;
    o_ba = 2'h0;
    o_addr = 12'h000;
    o_dq = 32'h00000000;
    o_dqs = 1'b0;
    o_dm = 4'h0;
  end

  // Set up half a cycle ahead so the rising edge sees settled pins.
  task cmd(input logic [3:0] c, input logic [1:0] b, input logic [11:0] a);
    @(negedge i_ck);
    {o_cs_n, o_ras_n, o_cas_n, o_we_n} = c;
    o_ba = b;
    o_addr = a;
    @(negedge i_ck);
    {o_cs_n, o_ras_n, o_cas_n, o_we_n} = 4'hF;
    o_ba = ~b;
    o_addr = ~a;
  endtask

  task nop(input int n);
    repeat (n) @(negedge i_ck);
  endtask

  // Masked beats still get strobe edges, else their mask is never latched.
  task burst(input int n, input logic [31:0] d [8], input logic [3:0] m [8]);
    for (int k = 0; k < n; k++) begin
      o_dq = d[k];
      o_dm = m[k];
      #31.25 o_dqs = ~o_dqs;
      #31.25;
    end
    o_dq = ~o_dq;
    o_dm = ~o_dm;
  endtask
endmodule
`default_nettype wire

// File: dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "dbs_defines.vh"
module testbench;
  logic        i_sys_clk = 1'b0;
  logic        i_nrst;
  logic        i_ck = 1'b0;
  logic [2:0]  i_column_latency;
  logic [1:0]  i_burst_length_setting;
  logic [7:0]  i_write_recovery_time;
  logic [7:0]  i_row_precharge_time;
  logic [7:0]  i_row_active_min_time;
  logic        i_wr_ready;
  logic        i_clr_overflow;
  logic        hold = 1'b0;
  logic        pdqs = 1'b0;
  logic        poe = 1'b0;
  wire         i_cs_n, i_ras_n, i_cas_n, i_we_n, i_dqs_in;
  wire  [1:0]  i_ba, o_wr_bank, o_rd_bank;
  wire  [11:0] i_addr;
  wire  [31:0] i_dq_in, o_dq_out, o_wr_data, i_rd_data;
  wire  [3:0]  i_write_byte_mask, o_wr_mask, o_bank_open, o_bank_closing;
  wire  [7:0]  o_wr_col, o_rd_col;
  wire         o_dq_oe, o_dqs_out, o_dqs_oe, o_wr_valid, o_wr_overflow;
  int          n_fail = 0;
  int          checks_done = 0;
  int          cyc = 0;
  logic [45:0] rq [$];
  logic [45:0] wq [$];

  always #4 i_sys_clk = ~i_sys_clk;
  always #62.5 i_ck = ~i_ck;

  // Array contents are a pure function of the address, so beats self-check.
  function automatic logic [31:0] rdv(input logic [1:0] b, input logic [7:0] c);
    rdv = {6'h2D, b, c, ~c, b, 6'h15};
  endfunction
  assign i_rd_data = rdv(o_rd_bank, o_rd_col);

  dbs_core dut (.i_sys_clk, .i_nrst, .i_ck, .i_cs_n, .i_ras_n, .i_cas_n,
    .i_we_n, .i_ba, .i_addr, .i_dq_in, .i_dqs_in, .i_write_byte_mask,
    .o_dq_out, .o_dq_oe, .o_dqs_out, .o_dqs_oe, .i_column_latency,
    .i_burst_length_setting, .i_write_recovery_time, .i_row_precharge_time,
    .i_row_active_min_time, .o_wr_valid, .i_wr_ready, .o_wr_bank, .o_wr_col,
    .o_wr_data, .o_wr_mask, .o_rd_bank, .o_rd_col, .i_rd_data, .o_bank_open,
    .o_bank_closing, .o_wr_overflow, .i_clr_overflow);
  dbs_ctrl_model ctl (.i_ck, .o_cs_n(i_cs_n), .o_ras_n(i_ras_n),
    .o_cas_n(i_cas_n), .o_we_n(i_we_n), .o_ba(i_ba), .o_addr(i_addr),
    .o_dq(i_dq_in), .o_dqs(i_dqs_in), .o_dm(i_write_byte_mask));

  // Random stalls on the array side; hold forces the queue to fill.
  always @(negedge i_sys_clk) begin
    i_wr_ready <= !hold && ($urandom_range(3) != 0);
  end

  // Collect read beats on strobe changes and beats leaving the queue.
  always @(posedge i_sys_clk) begin
    pdqs <= o_dqs_out;
    poe <= o_dqs_oe;
    if (o_dqs_oe && (!poe || o_dqs_out != pdqs))
      rq.push_back(46'(o_dq_out));
    if (o_wr_valid && i_wr_ready)
      wq.push_back({o_wr_bank, o_wr_col, o_wr_mask, o_wr_data});
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      end_of_test();
    end
  end

  task chk(input logic [45:0] got, input logic [45:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task end_of_test;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // A stop lands stop+1 clocks after the read, as each command spans two
  // link cycles; no stop is ever sent into an auto-close read.
  task automatic rd(input logic [1:0] b, input logic [7:0] c,
                    input logic ap, input int stop);
    int n;
    n = 1 << i_burst_length_setting;
    if (stop > 0 && !ap && 2 * (stop + 1) < n)
      n = 2 * (stop + 1);
    rq = {};
    ctl.cmd(`DBS_CMD_READ, b, {3'h0, ap, c});
    if (stop > 0 && !ap) begin
      ctl.nop(stop - 1);
      ctl.cmd(`DBS_CMD_BST, b, 12'h000);
    end
    ctl.nop(12);
    chk(46'(rq.size()), 46'(n));
    for (int k = 0; k < n; k++)
      chk(rq[k], 46'(rdv(b, c + k[7:0])));
  endtask

  // Precharge lands pre/2 + write recovery + 2 clocks after the write.
  task automatic wrt(input logic [1:0] b, input logic [7:0] c,
                     input logic ap, input int pre);
    logic [31:0] d [8];
    logic [3:0]  m [8];
    int n;
    int j;
    n = 1 << i_burst_length_setting;
    j = 0;
    for (int k = 0; k < 8; k++) begin
      d[k] = $urandom;
      m[k] = (k % 3 == 1) ? 4'hF : 4'($urandom_range(15));
      if (pre > 0 && k >= pre)
        m[k] = 4'hF;
    end
    wq = {};
    ctl.cmd(`DBS_CMD_WRITE, b, {3'h0, ap, c});
    fork
      ctl.burst(n, d, m);
      if (pre > 0) begin
        ctl.nop(pre / 2 + int'(i_write_recovery_time));
        ctl.cmd(`DBS_CMD_PRE, b, 12'h000);
      end
    join
    ctl.nop(12);
    for (int k = 0; k < n; k++)
      if (m[k] != 4'hF) begin
        chk(wq[j], {b, c + k[7:0], m[k], d[k]});
        j++;
      end
    chk(46'(wq.size()), 46'(j));
  endtask

  initial begin
    logic [31:0] dz [8];
    logic [3:0]  mz [8];
    void'($urandom(32'h2354));
    i_nrst = 1'b0;
    i_column_latency = 3'h2;
    i_burst_length_setting = 2'h2;
    i_write_recovery_time = 8'h02;
    i_row_precharge_time = 8'(2 + $urandom_range(2));
    i_row_active_min_time = 8'h04;
    i_clr_overflow = 1'b0;
    dz = '{default: 32'h5A5A0F0F};
    mz = '{default: 4'h0};
    repeat (16) @(posedge i_sys_clk);
    @(negedge i_sys_clk) i_nrst = 1'b1;
    ctl.nop(2);
    for (int b = 0; b < 4; b++)
      ctl.cmd(`DBS_CMD_ACT, b[1:0], 12'($urandom));
    ctl.nop(6);
    for (int c = 2; c < 4; c++)
      for (int l = 1; l < 4; l++) begin
        @(negedge i_sys_clk);
        i_column_latency = c[2:0];
        i_burst_length_setting = l[1:0];
        rd(2'($urandom), 8'($urandom_range(247)), 1'b0, 0);
      end
    rd(2'h0, 8'($urandom_range(247)), 1'b0, 1);
    rd(2'h1, 8'h20, 1'b0, 2);
    rd(2'h2, 8'h40, 1'b1, 0);
    chk(46'(o_bank_open[2]), 46'h0);
    @(negedge i_sys_clk) i_burst_length_setting = 2'h2;
    wrt(2'h3, 8'h10, 1'b0, 0);
    chk(46'(o_bank_open[3]), 46'h1);
    wrt(2'h1, 8'h80, 1'b1, 0);
    chk(46'(o_bank_open[1]), 46'h0);
    @(negedge i_sys_clk);
    i_burst_length_setting = 2'h3;
    i_write_recovery_time = 8'h01;
    wrt(2'h0, 8'hC0, 1'b0, 4);
    chk(46'(o_bank_open[0]), 46'h0);
    @(negedge i_sys_clk) i_row_active_min_time = 8'h06;
    ctl.cmd(`DBS_CMD_ACT, 2'h2, 12'h0A5);
    ctl.cmd(`DBS_CMD_PRE, 2'h2, 12'h000);
    ctl.nop(2);
    chk(46'(o_bank_open[2]), 46'h1);
    ctl.nop(6);
    chk(46'(o_bank_open[2]), 46'h0);
    hold = 1'b1;
    wq = {};
    repeat (2) begin
      ctl.cmd(`DBS_CMD_WRITE, 2'h3, 12'h010);
      ctl.burst(8, dz, mz);
    end
    ctl.nop(4);
    chk(46'(o_wr_overflow), 46'h1);
    hold = 1'b0;
    ctl.nop(8);
    chk(46'(wq.size()), 46'h8);
    @(negedge i_sys_clk) i_clr_overflow = 1'b1;
    @(negedge i_sys_clk) i_clr_overflow = 1'b0;
    @(negedge i_sys_clk) chk(46'(o_wr_overflow), 46'h0);
    end_of_test();
  end
endmodule

bind dbs_core dbs_core_chk chk_i (.i_sys_clk, .i_nrst, .i_ck, .i_wr_ready,
  .i_row_active_min_time, .o_dq_out, .o_dq_oe, .o_dqs_out, .o_dqs_oe,
  .o_wr_valid, .o_wr_data, .o_wr_mask, .o_wr_col, .o_bank_open,
  .o_bank_closing);
`default_nettype wire
